// ### hw/dcf_defs.svh
`ifndef DCF_DEFS_SVH
`define DCF_DEFS_SVH

// ------------------------------------------------------------
// synchronised pin vector layout
// ------------------------------------------------------------
`define DCF_SV_WCLK     0
`define DCF_SV_RCLK     1
`define DCF_SV_SCLK     2
`define DCF_SV_WEN_N    3
`define DCF_SV_REN_N    4
`define DCF_SV_IE_N     5
`define DCF_SV_OE_N     6
`define DCF_SV_LD_N     7
`define DCF_SV_REPLAY   8
`define DCF_SV_MARK     9
`define DCF_SV_WCLR_N   10
`define DCF_SV_PCLR_N   11
`define DCF_SV_MBOX     12
`define DCF_SV_SEN      13
`define DCF_SV_SDI      14
`define DCF_SV_PWS_LO   15
`define DCF_SV_PWS_HI   17
`define DCF_SV_DIN_LO   18
`define DCF_SV_DIN_HI   53
`define DCF_SV_WIDTH    54

// ------------------------------------------------------------
// configuration defaults and byte index
// ------------------------------------------------------------
`define DCF_NEAR_EMPTY_RST 16'h007f
`define DCF_NEAR_FULL_RST  16'h007f
`define DCF_CFG_AE_LO      2'h0
`define DCF_CFG_AE_HI      2'h1
`define DCF_CFG_AF_LO      2'h2
`define DCF_CFG_AF_HI      2'h3

// ------------------------------------------------------------
// lane widths per port width code
// ------------------------------------------------------------
`define DCF_BUS_W 36
`define DCF_LANES_9  36'h0_0000_01ff
`define DCF_LANES_12 36'h0_0000_0fff
`define DCF_LANES_16 36'h0_0000_ffff
`define DCF_LANES_18 36'h0_0003_ffff
`define DCF_LANES_20 36'h0_000f_ffff
`define DCF_LANES_24 36'h0_00ff_ffff
`define DCF_LANES_32 36'h0_ffff_ffff
`define DCF_LANES_36 36'hf_ffff_ffff

`endif

// ### hw/dcf_pkg.sv
package dcf_pkg;

	// ------------------------------------------------------------
	// port width codes
	// ------------------------------------------------------------
	typedef enum logic [2:0] {
		DCF_W9  = 3'b000,
		DCF_W12 = 3'b001,
		DCF_W16 = 3'b010,
		DCF_W18 = 3'b011,
		DCF_W20 = 3'b100,
		DCF_W24 = 3'b101,
		DCF_W32 = 3'b110,
		DCF_W36 = 3'b111
	} dcf_width_e;

	typedef logic [35:0] dcf_word_t;

endpackage

// ### hw/dcf_sync.sv
`timescale 1ns/1ps

// ------------------------------------------------------------
// two-flop synchroniser plus delayed copy for edge detection
// ------------------------------------------------------------
module dcf_sync
	import dcf_pkg::*;
#(
	parameter int WIDTH = 1
) (
	input  wire logic             core_clk,
	input  wire logic             reset,
	input  wire logic [WIDTH-1:0] pin_in,
	output logic      [WIDTH-1:0] level,
	output logic      [WIDTH-1:0] level_prev
);

	typedef struct packed {
		logic [WIDTH-1:0] meta;
		logic [WIDTH-1:0] sync;
		logic [WIDTH-1:0] prev;
	} dcf_sync_s;

	dcf_sync_s s_ff;
	dcf_sync_s nxt_s;

	always_comb begin
		nxt_s      = s_ff;
		nxt_s.meta = pin_in;
		nxt_s.sync = s_ff.meta;
		nxt_s.prev = s_ff.sync;
		if (reset) begin
			nxt_s = '0;
		end
	end

	always_ff @(posedge core_clk) begin
		s_ff <= nxt_s;
	end

	assign level      = s_ff.sync;
	assign level_prev = s_ff.prev;

endmodule

// ### hw/dcf_top.sv
// Function
// RULE_01: read order equals write order
// RULE_02: capture word on write clock rise
// RULE_03: present next word each read rise
// RULE_04: far side keeps clock ratio within limits
// RULE_05: reads and writes proceed concurrently
// RULE_06: clock rates up to 133 MHz supported
// RULE_07: empty, full, half, near flags provided
// RULE_08: selectable port widths mask data lanes
// RULE_09: replay moves read pointer to mark
// RULE_10: whole clear empties the buffer
// RULE_11: partial clear keeps configuration
// RULE_12: mailbox register bypasses the queue
// RULE_13: lane enables mask writes, skip reads
// RULE_14: offsets load parallel or serially
// RULE_15: write pointer advances regardless of lane enable
// RULE_16: empty and full flags active low
// RULE_17: load select routes low byte to configuration
// RULE_18: whole clear zeroes pointers, output, config; the offsets load 16'h007f instead
// RULE_19: ignore writes when full, reads when empty
// RULE_20: half flag when over half capacity
//
// The strobed register port and the address map were left to the implementer.
`timescale 1ns/1ps
`include "dcf_defs.svh"

module dcf_top
	import dcf_pkg::*;
#(
	parameter int DEPTH = 256
) (
	input  wire logic        core_clk,
	input  wire logic        reset,
	input  wire logic        write_clk,
	input  wire logic        read_clk,
	input  wire logic        serial_clk,
	input  wire logic        write_en_n,
	input  wire logic        read_en_n,
	input  wire logic        input_lane_enable_n,
	input  wire logic        output_drive_enable_n,
	input  wire logic        config_load_select_n,
	input  wire logic        replay_request,
	input  wire logic        mark_request,
	input  wire logic        whole_clear_reset_n,
	input  wire logic        partial_clear_reset_n,
	input  wire logic        bypass_register_select,
	input  wire logic        serial_program_enable,
	input  wire logic        serial_data_in,
	input  wire logic [2:0]  port_width_select,
	input  wire logic [35:0] din,
	output logic      [35:0] dout,
	output logic             dout_oe,
	output logic             output_word_valid,
	output logic             empty_flag_n,
	output logic             full_flag_n,
	output logic             half_fill_flag_n,
	output logic             near_empty_flag_n,
	output logic             near_full_flag_n
);

	localparam int AW = $clog2(DEPTH);

	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	typedef struct packed {
		logic [AW:0]  wp;
		logic [AW:0]  rp;
		logic [AW:0]  mark;
		logic [35:0]  dout;
		logic         dout_oe;
		logic         valid;
		logic [35:0]  mbox;
		logic [15:0]  near_empty_ofs;
		logic [15:0]  near_full_ofs;
		logic [1:0]   cfg_wr_idx;
		logic [1:0]   cfg_rd_idx;
		logic         empty_n;
		logic         full_n;
		logic         half_n;
		logic         near_empty_n;
		logic         near_full_n;
	} dcf_state_s;

	dcf_state_s s_ff;
	dcf_state_s nxt_s;

	dcf_word_t  mem [DEPTH];
	logic       mem_we;
	logic [AW-1:0] mem_wa;
	dcf_word_t  mem_wd;
	dcf_word_t  mem_rd;

	// ------------------------------------------------------------
	// pin synchronisation
	// ------------------------------------------------------------
	logic [`DCF_SV_WIDTH-1:0] pins;
	logic [`DCF_SV_WIDTH-1:0] lvl;
	logic [`DCF_SV_WIDTH-1:0] lvl_prev;

	assign pins = {
		din,
		port_width_select,
		serial_data_in,
		serial_program_enable,
		bypass_register_select,
		partial_clear_reset_n,
		whole_clear_reset_n,
		mark_request,
		replay_request,
		config_load_select_n,
		output_drive_enable_n,
		input_lane_enable_n,
		read_en_n,
		write_en_n,
		serial_clk,
		read_clk,
		write_clk
	};

	dcf_sync #( // RULE_06
		.WIDTH (`DCF_SV_WIDTH)
	) u_sync (
		.core_clk   (core_clk),
		.reset      (reset),
		.pin_in     (pins),
		.level      (lvl),
		.level_prev (lvl_prev)
	);

	logic        wr_rise;
	logic        rd_rise;
	logic        sclk_rise;
	logic        replay_rise;
	logic        mark_rise;
	logic        wen_n;
	logic        ren_n;
	logic        ie_n;
	logic        oe_n;
	logic        ld_n;
	logic        wclr_n;
	logic        pclr_n;
	logic        mbox_sel;
	logic        sen;
	logic        sdi;
	dcf_width_e  pws;
	dcf_word_t   din_s;

	assign wr_rise     = lvl[`DCF_SV_WCLK] & ~lvl_prev[`DCF_SV_WCLK];
	assign rd_rise     = lvl[`DCF_SV_RCLK] & ~lvl_prev[`DCF_SV_RCLK];
	assign sclk_rise   = lvl[`DCF_SV_SCLK] & ~lvl_prev[`DCF_SV_SCLK];
	assign replay_rise = lvl[`DCF_SV_REPLAY] & ~lvl_prev[`DCF_SV_REPLAY];
	assign mark_rise   = lvl[`DCF_SV_MARK] & ~lvl_prev[`DCF_SV_MARK];
	assign wen_n       = lvl[`DCF_SV_WEN_N];
	assign ren_n       = lvl[`DCF_SV_REN_N];
	assign ie_n        = lvl[`DCF_SV_IE_N];
	assign oe_n        = lvl[`DCF_SV_OE_N];
	assign ld_n        = lvl[`DCF_SV_LD_N];
	assign wclr_n      = lvl[`DCF_SV_WCLR_N];
	assign pclr_n      = lvl[`DCF_SV_PCLR_N];
	assign mbox_sel    = lvl[`DCF_SV_MBOX];
	assign sen         = lvl[`DCF_SV_SEN];
	assign sdi         = lvl[`DCF_SV_SDI];
	assign pws         = dcf_width_e'(lvl[`DCF_SV_PWS_HI:`DCF_SV_PWS_LO]);
	assign din_s       = lvl[`DCF_SV_DIN_HI:`DCF_SV_DIN_LO];

	// ------------------------------------------------------------
	// lane mask per port width
	// ------------------------------------------------------------
	function automatic dcf_word_t lane_mask(input dcf_width_e w);
		dcf_word_t m;
		m = `DCF_LANES_36;
		case (w)
			DCF_W9: begin
				m = `DCF_LANES_9;
			end
			DCF_W12: begin
				m = `DCF_LANES_12;
			end
			DCF_W16: begin
				m = `DCF_LANES_16;
			end
			DCF_W18: begin
				m = `DCF_LANES_18;
			end
			DCF_W20: begin
				m = `DCF_LANES_20;
			end
			DCF_W24: begin
				m = `DCF_LANES_24;
			end
			DCF_W32: begin
				m = `DCF_LANES_32;
			end
			default: begin
				m = `DCF_LANES_36;
			end
		endcase
		return m;
	endfunction

	// ------------------------------------------------------------
	// configuration byte read-back
	// ------------------------------------------------------------
	function automatic logic [7:0] cfg_byte(
		input logic [1:0]  idx,
		input logic [15:0] ae,
		input logic [15:0] af
	);
		logic [7:0] b;
		b = 8'h00;
		case (idx)
			`DCF_CFG_AE_LO: begin
				b = ae[7:0];
			end
			`DCF_CFG_AE_HI: begin
				b = ae[15:8];
			end
			`DCF_CFG_AF_LO: begin
				b = af[7:0];
			end
			default: begin
				b = af[15:8];
			end
		endcase
		return b;
	endfunction

	// ------------------------------------------------------------
	// next state
	// ------------------------------------------------------------
	logic [AW:0] cnt_now;
	logic [AW:0] cnt_nxt;
	logic        is_full;
	logic        is_empty;

	assign cnt_now  = s_ff.wp - s_ff.rp;
	assign is_full  = (cnt_now == (AW+1)'(DEPTH));
	assign is_empty = (cnt_now == '0);
	assign mem_rd   = mem[s_ff.rp[AW-1:0]];

	always_comb begin
		nxt_s   = s_ff;
		mem_we  = 1'b0;
		mem_wa  = s_ff.wp[AW-1:0];
		mem_wd  = din_s & lane_mask(pws); // RULE_08
		cnt_nxt = '0;

		nxt_s.dout_oe = ~oe_n;

		// write side
		if (wr_rise && !wen_n) begin // RULE_05
			if (!ld_n) begin
				case (s_ff.cfg_wr_idx) // RULE_17
					`DCF_CFG_AE_LO: begin
						nxt_s.near_empty_ofs[7:0] = din_s[7:0];
					end
					`DCF_CFG_AE_HI: begin
						nxt_s.near_empty_ofs[15:8] = din_s[7:0];
					end
					`DCF_CFG_AF_LO: begin
						nxt_s.near_full_ofs[7:0] = din_s[7:0];
					end
					default: begin
						nxt_s.near_full_ofs[15:8] = din_s[7:0];
					end
				endcase
				nxt_s.cfg_wr_idx = s_ff.cfg_wr_idx + 2'h1; // RULE_14
			end else if (mbox_sel) begin
				nxt_s.mbox = din_s & lane_mask(pws); // RULE_12
			end else if (!is_full) begin // RULE_19
				mem_we   = ~ie_n; // RULE_13
				nxt_s.wp = s_ff.wp + (AW+1)'(1); // RULE_15
			end
		end

		// serial programming of offsets
		if (sclk_rise && sen) begin
			{nxt_s.near_full_ofs, nxt_s.near_empty_ofs} =
				{nxt_s.near_full_ofs[14:0], nxt_s.near_empty_ofs, sdi}; // RULE_14
		end

		// read side
		if (rd_rise && !ren_n) begin // RULE_05
			if (!ld_n) begin
				nxt_s.dout       = {28'h0000000, cfg_byte(s_ff.cfg_rd_idx, s_ff.near_empty_ofs,
				                                          s_ff.near_full_ofs)}; // RULE_17
				nxt_s.valid      = 1'b1;
				nxt_s.cfg_rd_idx = s_ff.cfg_rd_idx + 2'h1;
			end else if (mbox_sel) begin
				nxt_s.dout  = s_ff.mbox; // RULE_12
				nxt_s.valid = 1'b1;
			end else if (!is_empty) begin // RULE_19
				nxt_s.rp = s_ff.rp + (AW+1)'(1); // RULE_01
				if (!oe_n) begin
					nxt_s.dout  = mem_rd & lane_mask(pws); // RULE_03
					nxt_s.valid = 1'b1;
				end else begin
					nxt_s.valid = 1'b0; // RULE_13
				end
			end else begin
				nxt_s.valid = 1'b0;
			end
		end

		// mark and replay
		if (mark_rise) begin
			nxt_s.mark = s_ff.rp;
		end
		if (replay_rise) begin
			nxt_s.rp = s_ff.mark; // RULE_09
		end

		// clears
		if (reset || !wclr_n) begin
			nxt_s                = '0; // RULE_10
			nxt_s.near_empty_ofs = `DCF_NEAR_EMPTY_RST; // RULE_18
			nxt_s.near_full_ofs  = `DCF_NEAR_FULL_RST;
			nxt_s.dout_oe        = 1'b0;
			mem_we               = 1'b0;
		end else if (!pclr_n) begin
			nxt_s.wp         = '0; // RULE_11
			nxt_s.rp         = '0;
			nxt_s.mark       = '0;
			nxt_s.dout       = '0;
			nxt_s.valid      = 1'b0;
			nxt_s.cfg_wr_idx = 2'h0;
			nxt_s.cfg_rd_idx = 2'h0;
			mem_we           = 1'b0;
		end

		// flags from the next fill level
		cnt_nxt            = nxt_s.wp - nxt_s.rp;
		nxt_s.empty_n      = (cnt_nxt != '0); // RULE_16
		nxt_s.full_n       = (cnt_nxt != (AW+1)'(DEPTH)); // RULE_16
		nxt_s.half_n       = !(32'(cnt_nxt) > (DEPTH / 2)); // RULE_20
		nxt_s.near_empty_n = !(32'(cnt_nxt) <= 32'(nxt_s.near_empty_ofs)); // RULE_07
		nxt_s.near_full_n  = !(32'(cnt_nxt) + 32'(nxt_s.near_full_ofs) >= DEPTH); // RULE_07
	end

	// ------------------------------------------------------------
	// registers
	// ------------------------------------------------------------
	always_ff @(posedge core_clk) begin
		s_ff <= nxt_s;
	end

	always_ff @(posedge core_clk) begin
		if (mem_we) begin
			mem[mem_wa] <= mem_wd; // RULE_02
		end
	end

	// ------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------
	assign dout              = s_ff.dout;
	assign dout_oe           = s_ff.dout_oe;
	assign output_word_valid = s_ff.valid;
	assign empty_flag_n      = s_ff.empty_n;
	assign full_flag_n       = s_ff.full_n;
	assign half_fill_flag_n  = s_ff.half_n;
	assign near_empty_flag_n = s_ff.near_empty_n;
	assign near_full_flag_n  = s_ff.near_full_n;

endmodule

// ### sim/dcf_far_model.sv
`timescale 1ns/1ps

// -------------------------------------
// writer, reader and serial clock source
// -------------------------------------
module dcf_far_model (
	output logic write_clk,
	output logic read_clk,
	output logic serial_clk
);
	initial begin
		write_clk = 1'b0;
		read_clk = 1'b0;
		serial_clk = 1'b0;
	end

	// one 770 ns frame; clocks idle low between frames, equal rates
	task automatic tick(input logic w, r, s);
		#30;
		write_clk = w;
		read_clk = r;
		serial_clk = s;
		#400;
		write_clk = 1'b0;
		read_clk = 1'b0;
		serial_clk = 1'b0;
		#340;
	endtask
endmodule

// ### sim/dcf_monitor.sv
`timescale 1ns/1ps

// ------------
// port checker
// ------------
module dcf_monitor (
	input wire logic        core_clk,
	input wire logic        reset,
	input wire logic        write_clk,
	input wire logic        output_drive_enable_n,
	input wire logic        whole_clear_reset_n,
	input wire logic        partial_clear_reset_n,
	input wire logic [35:0] dout,
	input wire logic        dout_oe,
	input wire logic        output_word_valid,
	input wire logic        empty_flag_n,
	input wire logic        full_flag_n,
	input wire logic        half_fill_flag_n,
	input wire logic        near_empty_flag_n
);
	default clocking mc @(posedge core_clk);
	endclocking
	default disable iff (reset);

	a_reset_clears: assert property (disable iff (1'b0)
		reset |=> dout == 36'h0 && !output_word_valid && !dout_oe && !empty_flag_n && full_flag_n)
		else $error("reset state wrong");
	a_full_excl_empty: assert property (!full_flag_n |-> empty_flag_n)
		else $error("full and empty together");
	a_full_above_half: assert property (!full_flag_n |-> !half_fill_flag_n)
		else $error("full without half");
	a_half_not_empty: assert property (!half_fill_flag_n |-> empty_flag_n)
		else $error("half while empty");
	a_empty_near_empty: assert property (!empty_flag_n |-> !near_empty_flag_n)
		else $error("empty without near empty");
	a_full_needs_write: assert property ($fell(full_flag_n) |->
		$past(write_clk, 3) || $past(write_clk, 4) || $past(write_clk, 5))
		else $error("full without write");
	a_clear_empties: assert property ((!whole_clear_reset_n)[*4] |=>
		!empty_flag_n && full_flag_n && !dout_oe && dout == 36'h0)
		else $error("whole clear failed");
	a_partial_empties: assert property ((!partial_clear_reset_n && whole_clear_reset_n)[*4] |=>
		!empty_flag_n && full_flag_n && half_fill_flag_n)
		else $error("partial clear failed");
	a_oe_on: assert property ((!output_drive_enable_n && whole_clear_reset_n)[*4] |=> dout_oe)
		else $error("output not enabled");
	a_oe_off: assert property (output_drive_enable_n[*4] |=> !dout_oe)
		else $error("output not disabled");
endmodule

bind dcf_top dcf_monitor mon (.core_clk, .reset, .write_clk, .output_drive_enable_n, .whole_clear_reset_n,
	.partial_clear_reset_n, .dout, .dout_oe, .output_word_valid, .empty_flag_n, .full_flag_n,
	.half_fill_flag_n, .near_empty_flag_n);

// ### sim/dcf_top_bench.sv
`timescale 1ns/1ps

module dcf_top_bench
	import dcf_pkg::*;
;
	localparam int DP = 16;

	logic       core_clk              = 1'b0;
	logic       reset                 = 1'b1;
	logic       write_en_n            = 1'b1;
	logic       read_en_n             = 1'b1;
	logic       serial_program_enable = 1'b0;
	logic       serial_data_in        = 1'b0;
	logic [2:0] port_width_select     = 3'h7;
	logic [3:0] ctl                   = 4'h4;
	logic [3:0] ev                    = 4'h0;
	dcf_word_t  din                   = 36'h0;
	dcf_word_t  seed                  = 36'h04d;
	dcf_word_t  last                  = 36'h0;
	dcf_word_t  mb                    = 36'h0;
	dcf_word_t  dout;
	dcf_word_t  q[$];
	dcf_word_t  qm[$];
	logic [7:0] cfg[4]                = '{8'h7f, 8'h00, 8'h7f, 8'h00};
	logic       v                     = 1'b0;
	wire        write_clk, read_clk, serial_clk, dout_oe, output_word_valid;
	wire  [4:0] fl;
	int         wi, ri, err_count, tests_run;

	dcf_far_model far (.write_clk, .read_clk, .serial_clk);

	dcf_top #(.DEPTH(DP)) uut (
		.core_clk, .reset, .write_clk, .read_clk, .serial_clk, .write_en_n, .read_en_n,
		.input_lane_enable_n (ctl[0]), .output_drive_enable_n (ctl[1]), .config_load_select_n (ctl[2]),
		.bypass_register_select (ctl[3]), .mark_request (ev[0]), .replay_request (ev[1]),
		.whole_clear_reset_n (!ev[2]), .partial_clear_reset_n (!ev[3]), .serial_program_enable,
		.serial_data_in, .port_width_select, .din, .dout, .dout_oe, .output_word_valid,
		.empty_flag_n (fl[4]), .full_flag_n (fl[3]), .half_fill_flag_n (fl[2]),
		.near_empty_flag_n (fl[1]), .near_full_flag_n (fl[0]));

	function automatic dcf_word_t rnd();
		seed = {seed[34:0], seed[35] ^ seed[24]};
		return seed;
	endfunction

	function automatic dcf_word_t lanes(input logic [2:0] w);
		int n[8] = '{9, 12, 16, 18, 20, 24, 32, 36};
		return (36'h1 << n[w]) - 36'h1;
	endfunction

	function automatic logic [5:0] stat_exp(input int n);
		int ae = int'({cfg[1], cfg[0]});
		int af = int'({cfg[3], cfg[2]});
		return {v, n != 0, n != DP, n <= DP / 2, n > ae, n < DP - af};
	endfunction

	task automatic chk_word(input dcf_word_t got, input dcf_word_t exp);
		tests_run++;
		if (got !== exp) begin
			err_count++;
			$display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic chk_stat(input logic [5:0] got, input logic [5:0] exp);
		tests_run++;
		if (got !== exp) begin
			err_count++;
			$display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic note(input string s);
		$display("test %s done", s);
	endtask

	task automatic conclude();
		$display("comparisons %0d mismatches %0d", tests_run, err_count);
		if (err_count == 0 && tests_run > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	task automatic go(input logic w, r, input logic [3:0] c, input dcf_word_t dd);
		@(posedge core_clk);
		write_en_n <= !w;
		read_en_n <= !r;
		ctl <= c;
		din <= dd;
		repeat (3) @(posedge core_clk);
		far.tick(w, r, 1'b0);
	endtask

	// k: 0 write, 1 read, 2 both; c: bypass, load select, skip, mask
	task automatic op(input int k, input logic [3:0] c, input dcf_word_t dd);
		dcf_word_t m;
		logic      w, r;
		w = k != 1;
		r = k != 0;
		go(w, r, c, dd);
		m = dd & lanes(port_width_select);
		if (!c[2]) begin
			if (w) begin
				cfg[wi] = dd[7:0];
				wi = (wi + 1) % 4;
			end
			if (r) begin
				last = {28'h0, cfg[ri]};
				ri = (ri + 1) % 4;
				v = 1'b1;
			end
		end else if (c[3]) begin
			mb = w ? m : mb;
			last = r ? mb : last;
			v = r ? 1'b1 : v;
		end else begin
			if (r) begin
				v = q.size() > 0 && !c[1];
				if (v)
					last = q[0];
				if (q.size() > 0)
					void'(q.pop_front());
			end
			if (w && q.size() < DP)
				q.push_back(m);
		end
		chk_word(dout, last);
		chk_stat({output_word_valid, fl}, stat_exp(q.size()));
	endtask

	task automatic pulse(input int i);
		@(posedge core_clk);
		ev[i] <= 1'b1;
		repeat (6) @(posedge core_clk);
		ev[i] <= 1'b0;
		repeat (6) @(posedge core_clk);
		#10;
	endtask

	initial begin
		forever #50 core_clk = ~core_clk;
	end

	initial begin
		#2_000_000;
		err_count++;
		conclude();
	end

	initial begin
		logic [31:0] s;
		logic [7:0]  pb[4];
		int          k;
		pb = '{8'h04, 8'h00, 8'h03, 8'h00};
		s = 32'h0002_0002;
		repeat (5) @(posedge core_clk);
		reset <= 1'b0;
		repeat (4) @(posedge core_clk);
		#10;
		chk_stat({output_word_valid, fl}, stat_exp(0));
		chk_word(dout, 36'h0);
		note("reset");
		for (int i = 31; i >= 0; i--) begin
			@(posedge core_clk);
			serial_program_enable <= 1'b1;
			serial_data_in <= s[i];
			repeat (3) @(posedge core_clk);
			far.tick(1'b0, 1'b0, 1'b1);
		end
		@(posedge core_clk);
		serial_program_enable <= 1'b0;
		{cfg[3], cfg[2], cfg[1], cfg[0]} = s;
		repeat (4) op(1, 4'h0, 36'h0);
		for (int i = 0; i < 4; i++) op(0, 4'h0, {28'h0, pb[i]});
		repeat (4) op(1, 4'h0, 36'h0);
		note("config");
		repeat (40) begin
			k = int'(rnd() % 36'h3);
			if (k == 2 && (q.size() == 0 || q.size() == DP))
				k = q.size() == 0 ? 0 : 1;
			op(k, 4'h4, rnd());
		end
		repeat (DP) op(1, 4'h4, 36'h0);
		note("random");
		for (int w = 0; w < 8; w++) begin
			@(posedge core_clk);
			port_width_select <= 3'(w);
			op(0, 4'h4, rnd());
			op(1, 4'h4, 36'h0);
		end
		note("widths");
		repeat (DP + 1) op(0, 4'h4, rnd());
		op(0, 4'hc, rnd());
		op(1, 4'hc, 36'h0);
		repeat (DP + 1) op(1, 4'h4, 36'h0);
		note("fill and bypass");
		op(0, 4'h4, rnd());
		op(0, 4'h5, rnd());
		op(0, 4'h4, rnd());
		op(1, 4'h4, 36'h0);
		op(1, 4'h6, 36'h0);
		op(1, 4'h4, 36'h0);
		note("mask and skip");
		repeat (3) op(0, 4'h4, rnd());
		pulse(0);
		qm = q;
		repeat (2) op(1, 4'h4, 36'h0);
		pulse(1);
		q = qm;
		chk_stat({output_word_valid, fl}, stat_exp(q.size()));
		repeat (3) op(1, 4'h4, 36'h0);
		note("replay");
		repeat (2) op(0, 4'h4, rnd());
		pulse(3);
		q.delete();
		wi = 0;
		ri = 0;
		v = 1'b0;
		last = 36'h0;
		chk_word(dout, last);
		chk_stat({output_word_valid, fl}, stat_exp(0));
		op(1, 4'h0, 36'h0);
		note("partial clear");
		pulse(2);
		cfg = '{8'h7f, 8'h00, 8'h7f, 8'h00};
		v = 1'b0;
		chk_stat({output_word_valid, fl}, stat_exp(0));
		chk_word(dout, 36'h0);
		go(1'b0, 1'b1, 4'h0, 36'h0);
		chk_word(dout, 36'h07f);
		note("whole clear");
		conclude();
	end
endmodule
